// [rtl/dps_consts.svh]
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
// Clock and protection tick
`define DPS_CLK_MHZ 50
`define DPS_TICK_US 32
`define DPS_TICK_CYC (`DPS_CLK_MHZ * `DPS_TICK_US)
// Register byte offsets
`define DPS_OFS_CTRL 8'h00
`define DPS_OFS_DUTY 8'h04
`define DPS_OFS_CURR 8'h08
`define DPS_OFS_DTHR 8'h0c
`define DPS_OFS_TEMP 8'h10
`define DPS_OFS_VOV 8'h14
`define DPS_OFS_REACT 8'h18
`define DPS_OFS_BLK01 8'h1c
`define DPS_OFS_BLK23 8'h20
`define DPS_OFS_RST 8'h24
`define DPS_OFS_WDOG 8'h28
`define DPS_OFS_KICK 8'h2c
`define DPS_OFS_STAT 8'h30
`define DPS_OFS_MEM 8'h40
// Control bit positions
`define DPS_CTRL_QUAD 0
`define DPS_CTRL_INV 1
`define DPS_CTRL_HYST 2
`define DPS_CTRL_DOFF 3
// Reset values
`define DPS_RST_CTRL 32'h0000_0000
`define DPS_RST_DUTY 32'h0040_ff00
`define DPS_RST_CURR 32'h0fff_0000
`define DPS_RST_DTHR 32'h0010_0802
`define DPS_RST_TEMP 32'h0b00_0c00
`define DPS_RST_VOV 32'h0000_0e00
`define DPS_RST_REACT 32'h0000_0000
`define DPS_RST_BLK 32'h0010_0010
`define DPS_RST_RST 32'h0010_0100
`define DPS_RST_WDOG 32'h0000_0000
// Error codes
`define DPS_ERR_NONE 4'h0
`define DPS_ERR_OT 4'h1
`define DPS_ERR_VOV 4'h2
`define DPS_ERR_WD 4'h3
`define DPS_ERR_PAR 4'h4
`endif

// [rtl/dps_pkg.sv]
package dps_pkg;
  typedef enum logic [1:0] {
    DPS_AUTO,
    DPS_FAST,
    DPS_LATCH,
    DPS_STOP
  } dps_react_t;
  typedef enum logic [2:0] {
    DPS_S_START,
    DPS_S_RUN,
    DPS_S_TRIP,
    DPS_S_LATCH,
    DPS_S_STOP,
    DPS_S_ARWAIT,
    DPS_S_DOFF,
    DPS_S_RECHG
  } dps_state_t;
endpackage

// [rtl/dps_blank.sv]
`timescale 1ns/1ps
module dps_blank (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fault level and blanking length in cycles
  input wire logic fault,
  input wire logic [15:0] blank,
  // Trigger level
  output logic trig
);
  logic [15:0] cnt_reg, cnt_next;
  logic trig_reg, trig_next;
  always_comb begin
    cnt_next = 16'h0000;
    if (fault && cnt_reg != 16'hffff) begin
      cnt_next = cnt_reg + 16'h0001;
    end else if (fault) begin
      cnt_next = cnt_reg;
    end
    trig_next = fault && (cnt_reg >= blank);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 16'h0000;
      trig_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      trig_reg <= trig_next;
    end
  end
  assign trig = trig_reg;
endmodule

// [rtl/dps_mem.sv]
`timescale 1ns/1ps
module dps_mem #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  // Clock
  input wire logic aclk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata,
  output logic perr
);
  logic [DW:0] mem [2**AW];
  logic [DW:0] word_reg;
  logic valid_reg;
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= {^wdata, wdata};
    end
    word_reg <= mem[raddr];
    valid_reg <= re;
  end
  assign rdata = word_reg[DW-1:0];
  assign perr = valid_reg && (^word_reg);
endmodule

// [rtl/dps_top.sv]
// Operation
// - Measure dimming input duty cycle and derive current target from it.
// - Duty to current mapping is linear or quadratic by setting.
// - Setting selects normal or inverted dimming curve.
// - Lower and upper duty levels map to minimum and maximum current.
// - With hysteresis on, small duty changes keep the target.
// - Dim-to-off stops light by running auto-restart cycles.
// - In dim-to-off each restart recharges only to startup voltage.
// - Dim-to-off is entered when duty passes the off threshold.
// - Regulation resumes when duty passes the separate on threshold.
// - Protection triggers only after fault outlasts its blanking time.
// - Overtemperature above critical level starts a shutdown.
// - Overtemperature auto-restart waits until below hot level.
// - Overtemperature latch stays off until power cycle, then below critical.
// - Supply above overvoltage level past its blanking triggers protection.
// - Supply overvoltage reaction is always stop.
// - Watchdog trips unless firmware services it within its period.
// - Working memory parity error triggers a protection.
// - Each protection has its own reaction: auto, fast, latch, stop.
// - Related driver off within four ticks, others within four more.
// - Latch ends in latch mode; stop enters serial parametrization.
// - Auto-restart waits its restart time, then soft start.
// - Stage one restarts first; stage two follows when its condition holds.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dps_consts.svh"
module dps_top import dps_pkg::*; #(
  parameter int DUTY_WIN_LOG2 = 19,
  parameter int TICK_CYC = `DPS_TICK_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Sensed inputs
  input wire logic pwm_dim_in,
  input wire logic [11:0] temp_meas,
  input wire logic [11:0] vcc_meas,
  input wire logic stage1_ready,
  input wire logic stage2_cond,
  input wire logic vout_start_ok,
  // Power stage control
  output logic [1:0] gate_drive_output,
  output logic recharge_only,
  output logic uart_param_mode,
  output logic latch_mode,
  output logic [11:0] current_target,
  output logic [3:0] error_code,
  output logic dim_off
);
  localparam int NREG = 11;
  localparam int NP = 4;
  // Register file and bus state
  logic [31:0] cfg_reg [NREG];
  logic [31:0] cfg_next [NREG];
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] waddr_reg, waddr_next, raddr_reg, raddr_next;
  logic [31:0] wdat_reg, wdat_next;
  logic [3:0] wstb_reg, wstb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic rpend_reg, rpend_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic kick, mem_we, mem_re, perr, wr_go, rd_go;
  logic [3:0] mem_ra, scrub_reg, scrub_next;
  logic [15:0] mem_rd;
  logic [31:0] wmask;
  // Timebase, duty, target
  logic [15:0] tdiv_reg, tdiv_next;
  logic tick_reg, tick_next;
  logic [DUTY_WIN_LOG2-1:0] win_reg, win_next, hi_reg, hi_next;
  logic [7:0] duty_reg, duty_next, held_reg, held_next;
  logic [7:0] dc, diff, fr, fr2, dlt;
  logic [15:0] prod, sq;
  logic [11:0] span, tgt_reg, tgt_next;
  logic [19:0] tprod;
  // Protections and sequencer
  logic [NP-1:0] fault, trig;
  logic [15:0] blank [NP];
  logic [15:0] wd_reg, wd_next, cnt_reg, cnt_next;
  logic par_reg, par_next;
  dps_state_t st_reg, st_next;
  dps_react_t re_reg, re_next, rsel;
  logic [1:0] gd_reg, gd_next;
  logic rel_reg, rel_next, rsel_stage;
  logic [3:0] err_reg, err_next;
  logic doff_reg, doff_next;
  logic [15:0] ar_time;

  assign wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
  assign rd_go = arvalid && !rpend_reg && !rvalid_reg;
  assign kick = wr_go && waddr_reg == `DPS_OFS_KICK;
  assign mem_we = wr_go && waddr_reg[7:6] == 2'b01;
  assign mem_re = (rd_go && araddr[7:6] == 2'b01) || tick_reg;
  assign mem_ra = (rd_go && araddr[7:6] == 2'b01) ? araddr[5:2] : scrub_reg;
  assign wmask = {{8{wstb_reg[3]}}, {8{wstb_reg[2]}},
                  {8{wstb_reg[1]}}, {8{wstb_reg[0]}}};

  dps_mem #(.AW(4), .DW(16)) u_mem (
    .aclk(aclk),
    .we(mem_we),
    .waddr(waddr_reg[5:2]),
    .wdata(wdat_reg[15:0]),
    .re(mem_re),
    .raddr(mem_ra),
    .rdata(mem_rd),
    .perr(perr)
  );

  // Bus slave
  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    waddr_next = waddr_reg;
    wdat_next = wdat_reg;
    wstb_next = wstb_reg;
    bvalid_next = bvalid_reg && !bready;
    bresp_next = bresp_reg;
    rpend_next = rpend_reg;
    raddr_next = raddr_reg;
    rvalid_next = rvalid_reg && !rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    scrub_next = (tick_reg && !rd_go) ? scrub_reg + 4'h1 : scrub_reg;
    for (int i = 0; i < NREG; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    if (awvalid && !aw_have_reg) begin
      aw_have_next = 1'b1;
      waddr_next = {awaddr[7:2], 2'b00};
    end
    if (wvalid && !w_have_reg) begin
      w_have_next = 1'b1;
      wdat_next = wdata;
      wstb_next = wstrb;
    end
    if (wr_go) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = 2'b00;
      if (waddr_reg < `DPS_OFS_KICK) begin
        cfg_next[waddr_reg[5:2]] = (cfg_reg[waddr_reg[5:2]] & ~wmask)
                                 | (wdat_reg & wmask);
      end else if (waddr_reg != `DPS_OFS_KICK && !mem_we) begin
        bresp_next = 2'b11;
      end
    end
    if (rd_go) begin
      rpend_next = 1'b1;
      raddr_next = {araddr[7:2], 2'b00};
    end
    if (rpend_reg) begin
      rpend_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = 2'b00;
      rdata_next = 32'h0000_0000;
      if (raddr_reg < `DPS_OFS_KICK) begin
        rdata_next = cfg_reg[raddr_reg[5:2]];
      end else if (raddr_reg == `DPS_OFS_STAT) begin
        rdata_next = {2'b00, gd_reg, err_reg, 3'b000, doff_reg,
                      duty_reg, tgt_reg};
      end else if (raddr_reg[7:6] == 2'b01) begin
        rdata_next = {16'h0000, mem_rd};
      end else if (raddr_reg != `DPS_OFS_KICK) begin
        rresp_next = 2'b11;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg[0] <= `DPS_RST_CTRL;
      cfg_reg[1] <= `DPS_RST_DUTY;
      cfg_reg[2] <= `DPS_RST_CURR;
      cfg_reg[3] <= `DPS_RST_DTHR;
      cfg_reg[4] <= `DPS_RST_TEMP;
      cfg_reg[5] <= `DPS_RST_VOV;
      cfg_reg[6] <= `DPS_RST_REACT;
      cfg_reg[7] <= `DPS_RST_BLK;
      cfg_reg[8] <= `DPS_RST_BLK;
      cfg_reg[9] <= `DPS_RST_RST;
      cfg_reg[10] <= `DPS_RST_WDOG;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdat_reg <= 32'h0000_0000;
      wstb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
      rpend_reg <= 1'b0;
      raddr_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'b00;
      rdata_reg <= 32'h0000_0000;
      scrub_reg <= 4'h0;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      waddr_reg <= waddr_next;
      wdat_reg <= wdat_next;
      wstb_reg <= wstb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rpend_reg <= rpend_next;
      raddr_reg <= raddr_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      scrub_reg <= scrub_next;
    end
  end

  // Duty measurement and current target
  always_comb begin
    tdiv_next = tdiv_reg + 16'h0001;
    tick_next = 1'b0;
    if (tdiv_reg == 16'(TICK_CYC - 1)) begin
      tdiv_next = 16'h0000;
      tick_next = 1'b1;
    end
    win_next = win_reg + 1'b1;
    hi_next = hi_reg + DUTY_WIN_LOG2'(pwm_dim_in);
    duty_next = duty_reg;
    if (&win_reg) begin
      hi_next = '0;
      duty_next = hi_reg[DUTY_WIN_LOG2-1 -: 8];
    end
    dlt = (duty_reg > held_reg) ? duty_reg - held_reg : held_reg - duty_reg;
    held_next = held_reg;
    if (!cfg_reg[0][`DPS_CTRL_HYST] || dlt > cfg_reg[3][7:0]) begin
      held_next = duty_reg;
    end
    dc = held_reg;
    if (held_reg < cfg_reg[1][7:0]) begin
      dc = cfg_reg[1][7:0];
    end else if (held_reg > cfg_reg[1][15:8]) begin
      dc = cfg_reg[1][15:8];
    end
    diff = dc - cfg_reg[1][7:0];
    prod = diff * cfg_reg[1][23:16];
    fr = (prod[15:14] != 2'b00) ? 8'hff : prod[13:6];
    if (cfg_reg[0][`DPS_CTRL_INV]) begin
      fr = ~fr;
    end
    // Added term lets full scale reach 0xff after the shift
    sq = fr * fr + 16'(fr);
    fr2 = cfg_reg[0][`DPS_CTRL_QUAD] ? sq[15:8] : fr;
    span = (cfg_reg[2][27:16] > cfg_reg[2][11:0]) ?
           cfg_reg[2][27:16] - cfg_reg[2][11:0] : 12'h000;
    // Top half rounds up so full scale gives the whole span
    tprod = 20'(span * (9'(fr2) + 9'(fr2[7])));
    tgt_next = cfg_reg[2][11:0] + tprod[19:8];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tdiv_reg <= 16'h0000;
      tick_reg <= 1'b0;
      win_reg <= '0;
      hi_reg <= '0;
      duty_reg <= 8'h00;
      held_reg <= 8'h00;
      tgt_reg <= 12'h000;
    end else begin
      tdiv_reg <= tdiv_next;
      tick_reg <= tick_next;
      win_reg <= win_next;
      hi_reg <= hi_next;
      duty_reg <= duty_next;
      held_reg <= held_next;
      tgt_reg <= tgt_next;
    end
  end

  // Fault detection with per-protection blanking
  assign fault[0] = temp_meas > cfg_reg[4][11:0];
  assign fault[1] = vcc_meas > cfg_reg[5][11:0];
  assign fault[2] = cfg_reg[10][15:0] != 16'h0000 &&
                    wd_reg >= cfg_reg[10][15:0];
  assign fault[3] = par_reg;
  assign blank[0] = cfg_reg[7][15:0];
  assign blank[1] = cfg_reg[7][31:16];
  assign blank[2] = cfg_reg[8][15:0];
  assign blank[3] = cfg_reg[8][31:16];

  generate
    for (genvar p = 0; p < NP; p++) begin : g_prot
      dps_blank u_blank (
        .aclk(aclk),
        .aresetn(aresetn),
        .fault(fault[p]),
        .blank(blank[p]),
        .trig(trig[p])
      );
    end
  endgenerate

  // Reaction and stage of the highest-priority trigger
  always_comb begin
    rsel = dps_react_t'(cfg_reg[6][1:0]);
    rsel_stage = cfg_reg[6][8];
    err_next = `DPS_ERR_OT;
    if (!trig[0] && trig[1]) begin
      rsel = DPS_STOP;
      rsel_stage = cfg_reg[6][9];
      err_next = `DPS_ERR_VOV;
    end else if (!trig[0] && trig[2]) begin
      rsel = dps_react_t'(cfg_reg[6][5:4]);
      rsel_stage = cfg_reg[6][10];
      err_next = `DPS_ERR_WD;
    end else if (!trig[0] && trig[3]) begin
      rsel = dps_react_t'(cfg_reg[6][7:6]);
      rsel_stage = cfg_reg[6][11];
      err_next = `DPS_ERR_PAR;
    end
  end

  // Sequencer
  always_comb begin
    st_next = st_reg;
    re_next = re_reg;
    gd_next = gd_reg;
    rel_next = rel_reg;
    doff_next = doff_reg;
    cnt_next = tick_reg ? cnt_reg + 16'h0001 : cnt_reg;
    wd_next = (tick_reg && wd_reg != 16'hffff) ? wd_reg + 16'h0001 : wd_reg;
    par_next = par_reg || perr;
    ar_time = (re_reg == DPS_FAST) ? cfg_reg[9][31:16] : cfg_reg[9][15:0];
    if (kick || st_reg != DPS_S_RUN) begin
      wd_next = 16'h0000;
    end
    case (st_reg)
      DPS_S_START: begin
        par_next = perr;
        if (temp_meas <= cfg_reg[4][11:0]) begin
          gd_next = 2'b01;
          st_next = DPS_S_RUN;
        end
      end
      DPS_S_RUN, DPS_S_RECHG: begin
        if (st_reg == DPS_S_RUN && stage1_ready && stage2_cond) begin
          gd_next[1] = 1'b1;
        end
        if (|trig) begin
          re_next = rsel;
          rel_next = rsel_stage;
          gd_next[rsel_stage] = 1'b0;
          cnt_next = 16'h0000;
          st_next = DPS_S_TRIP;
        end else if (st_reg == DPS_S_RECHG &&
                     duty_reg >= cfg_reg[3][23:16]) begin
          doff_next = 1'b0;
          st_next = DPS_S_RUN;
        end else if (st_reg == DPS_S_RECHG && vout_start_ok) begin
          gd_next = 2'b00;
          cnt_next = 16'h0000;
          st_next = DPS_S_DOFF;
        end else if (st_reg == DPS_S_RUN && cfg_reg[0][`DPS_CTRL_DOFF] &&
                     duty_reg <= cfg_reg[3][15:8]) begin
          doff_next = 1'b1;
          gd_next = 2'b00;
          cnt_next = 16'h0000;
          st_next = DPS_S_DOFF;
        end
      end
      DPS_S_TRIP: begin
        if (tick_reg) begin
          gd_next = 2'b00;
          cnt_next = 16'h0000;
          case (re_reg)
            DPS_LATCH: st_next = DPS_S_LATCH;
            DPS_STOP: st_next = DPS_S_STOP;
            default: st_next = DPS_S_ARWAIT;
          endcase
        end
      end
      DPS_S_ARWAIT: begin
        if (cnt_reg >= ar_time && (err_reg != `DPS_ERR_OT ||
            temp_meas < cfg_reg[4][27:16])) begin
          doff_next = 1'b0;
          st_next = DPS_S_START;
        end
      end
      DPS_S_DOFF: begin
        if (cnt_reg >= cfg_reg[9][15:0]) begin
          gd_next = 2'b01;
          st_next = DPS_S_RECHG;
        end
      end
      DPS_S_LATCH, DPS_S_STOP: gd_next = 2'b00;
      default: st_next = DPS_S_START;
    endcase
  end

  // Error code is captured on a trigger and cleared on restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= DPS_S_START;
      re_reg <= DPS_AUTO;
      gd_reg <= 2'b00;
      rel_reg <= 1'b0;
      doff_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      wd_reg <= 16'h0000;
      par_reg <= 1'b0;
      err_reg <= `DPS_ERR_NONE;
    end else begin
      st_reg <= st_next;
      re_reg <= re_next;
      gd_reg <= gd_next;
      rel_reg <= rel_next;
      doff_reg <= doff_next;
      cnt_reg <= cnt_next;
      wd_reg <= wd_next;
      par_reg <= par_next;
      if (st_next == DPS_S_TRIP && st_reg != DPS_S_TRIP) begin
        err_reg <= err_next;
      end else if (st_reg == DPS_S_START) begin
        err_reg <= `DPS_ERR_NONE;
      end
    end
  end

  assign awready = !aw_have_reg;
  assign wready = !w_have_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = !rpend_reg && !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign gate_drive_output = gd_reg;
  assign recharge_only = st_reg == DPS_S_RECHG;
  assign uart_param_mode = st_reg == DPS_S_STOP;
  assign latch_mode = st_reg == DPS_S_LATCH;
  assign current_target = tgt_reg;
  assign error_code = err_reg;
  assign dim_off = doff_reg;
endmodule

// [testbench/dps_partner.sv]
`timescale 1ns/1ps
module dps_partner (
  // Clock and commanded duty
  input wire logic aclk,
  input wire logic [7:0] duty,
  // Gate drives from the device
  input wire logic [1:0] gate_drive_output,
  // Dimmer and stage feedback
  output logic pwm_dim_in,
  output logic stage1_ready,
  output logic stage2_cond,
  output logic vout_start_ok
);
  logic [7:0] ph = 8'h00;
  int s1 = 0;
  always @(posedge aclk) begin
    ph <= ph + 8'h01;
    s1 <= gate_drive_output[0] ? s1 + 1 : 0;
  end
  // PWM period of 256 cycles
  assign pwm_dim_in = ph < duty;
  // Soft start takes a while, stage two waits longer
  assign vout_start_ok = s1 > 20;
  assign stage1_ready = s1 > 40;
  assign stage2_cond = s1 > 90;
endmodule

// [testbench/dps_checker.sv]
`timescale 1ns/1ps
module dps_checker #(
  parameter int TICK_CYC = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Stage feedback
  input wire logic stage1_ready,
  input wire logic stage2_cond,
  // Sequencer outputs
  input wire logic [1:0] gate_drive_output,
  input wire logic recharge_only,
  input wire logic uart_param_mode,
  input wire logic latch_mode,
  input wire logic [3:0] error_code,
  input wire logic dim_off
);
  localparam int T8 = 8 * TICK_CYC + 2;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr_resp;
    awvalid && awready && wvalid && wready |-> ##[1:3] bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write unanswered");
  property p_rd_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_trip_off;
    $changed(error_code) && error_code != 4'h0 |-> ##[0:T8]
      gate_drive_output == 2'b00;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("gates stay on");
  property p_ov_stop;
    $rose(error_code == 4'h2) |-> ##[0:T8] uart_param_mode;
  endproperty
  a_ov_stop: assert property (p_ov_stop) else $error("no stop mode");
  property p_latch;
    latch_mode |=> latch_mode && gate_drive_output == 2'b00;
  endproperty
  a_latch: assert property (p_latch) else $error("latch left");
  property p_stop;
    uart_param_mode |=> uart_param_mode && gate_drive_output == 2'b00;
  endproperty
  a_stop: assert property (p_stop) else $error("stop left");
  property p_err_hold;
    latch_mode || uart_param_mode |=> $stable(error_code);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("code lost");
  property p_st2;
    $rose(gate_drive_output[1]) |-> $past(stage1_ready) && $past(stage2_cond);
  endproperty
  a_st2: assert property (p_st2) else $error("stage two early");
  property p_rech;
    recharge_only |-> dim_off;
  endproperty
  a_rech: assert property (p_rech) else $error("stray recharge");
  c_latch: cover property (latch_mode);
  c_stop: cover property (uart_param_mode);
  c_doff: cover property (recharge_only);
endmodule

// [testbench/dimming_and_protection_sequencer_tb.sv]
`timescale 1ns/1ps
`include "dps_consts.svh"
module dimming_and_protection_sequencer_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, duty = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] wdata = 32'h0;
  logic [11:0] temp_meas = 12'h400, vcc_meas = 12'h800;
  logic awready, wready, bvalid, arready, rvalid, pwm_dim_in;
  logic stage1_ready, stage2_cond, vout_start_ok, recharge_only;
  logic uart_param_mode, latch_mode, dim_off;
  logic [1:0] bresp, rresp, gate_drive_output, br, rr;
  logic [31:0] rdata, rv;
  logic [11:0] current_target, t0;
  logic [11:0] mid [4];
  logic [3:0] error_code;
  logic [7:0] dl [3] = '{8'h00, 8'h80, 8'hff};
  logic [31:0] rtab [11] = '{`DPS_RST_CTRL, `DPS_RST_DUTY, `DPS_RST_CURR,
    `DPS_RST_DTHR, `DPS_RST_TEMP, `DPS_RST_VOV, `DPS_RST_REACT,
    `DPS_RST_BLK, `DPS_RST_BLK, `DPS_RST_RST, `DPS_RST_WDOG};
  int fail_count = 0, cmp_count = 0, seed = 73856, d, n;
  logic seen;

  dps_top #(.DUTY_WIN_LOG2(10), .TICK_CYC(16)) dut (.*);
  dps_partner u_far (.aclk, .duty, .gate_drive_output, .pwm_dim_in,
    .stage1_ready, .stage2_cond, .vout_start_ok);

  initial begin
    forever #10 aclk = ~aclk;
  end

  task automatic wt(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    wt(2);
    aresetn <= 1'b1;
    wt(1);
  endtask
  task automatic chk(input logic [31:0] s, e, input string w);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", w, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bready && bvalid === 1'b1) begin
        bready <= 1'b0;
        br = bresp;
      end
    end while (awvalid || wvalid || bready);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rready && rvalid === 1'b1) begin
        rready <= 1'b0;
        rv = rdata;
        rr = rresp;
      end
    end while (arvalid || rready);
    chk(rv, e, "rdata");
    chk(rr, er, "rresp");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial begin
    #1200000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    rst();
    for (int i = 0; i < 11; i++) rchk(8'(i * 4), rtab[i], 2'b00);
    rchk(8'h34, 32'h0, 2'b11);
    wr(8'h34, 32'h1);
    chk(br, 2'b11, "bresp");
    wr(8'h40, 32'hbeef_1234);
    rchk(8'h40, 32'h0000_1234, 2'b00);
    wt(300);
    chk(gate_drive_output, 2'b11, "start");
    wr(8'h24, 32'h0010_0010);
    wr(8'h04, 32'h0050_f010);
    wr(8'h08, 32'h0e00_0100);
    // Bit 0 quadratic, bit 1 inverted
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, i);
      for (int k = 0; k < 3; k++) begin
        duty <= dl[k];
        wt(2200);
        if (k == 1) mid[i] = current_target;
        else chk(current_target, ((k == 2) ^ i[1]) ? 12'he00 : 12'h100,
          "target");
      end
    end
    chk(mid[1] < mid[0], 1, "quad");
    wr(8'h00, 32'h4);
    d = 64 + {$random(seed)} % 100;
    duty <= d[7:0];
    wt(2200);
    t0 = current_target;
    duty <= d[7:0] + 8'h01;
    wt(2200);
    chk(current_target, t0, "hyst");
    duty <= d[7:0] + 8'h20;
    wt(2200);
    chk(current_target != t0, 1, "track");
    wr(8'h00, 32'h8);
    duty <= 8'h00;
    wt(2200);
    chk(dim_off, 1, "dim_off");
    seen = 1'b0;
    repeat (1500) begin
      @(posedge aclk);
      if (recharge_only === 1'b1) seen = 1'b1;
    end
    chk(seen, 1, "recharge");
    duty <= 8'hc8;
    for (n = 0; n < 5000 && dim_off !== 1'b0; n++) @(posedge aclk);
    chk(dim_off, 0, "dim_on");
    // Overtemperature with short blanking and auto restart
    rst();
    wr(8'h24, 32'h0010_0010);
    wr(8'h10, 32'h0700_0900);
    wr(8'h1c, 32'h0010_0014);
    wt(300);
    repeat (2) begin
      temp_meas <= 12'ha00;
      wt(15);
      temp_meas <= 12'h400;
      wt(5);
    end
    chk(error_code, `DPS_ERR_NONE, "short");
    temp_meas <= 12'ha00;
    wt(40);
    chk(error_code, `DPS_ERR_OT, "ot");
    wt(140);
    chk(gate_drive_output, 2'b00, "off");
    temp_meas <= 12'h800;
    wt(600);
    chk(gate_drive_output, 2'b00, "hot");
    temp_meas <= 12'h400;
    wt(300);
    chk(gate_drive_output[0], 1, "restart");
    // Watchdog with fast restart
    rst();
    wr(8'h18, 32'h10);
    wt(300);
    // Service first so the period starts from zero
    wr(8'h2c, 32'h0);
    wr(8'h28, 32'h4);
    repeat (5) begin
      wt(30);
      wr(8'h2c, 32'h0);
    end
    chk(error_code, `DPS_ERR_NONE, "kicked");
    wt(300);
    chk(error_code, `DPS_ERR_WD, "wd");
    wr(8'h28, 32'h0);
    wt(500);
    chk(gate_drive_output[0], 1, "fast");
    // Supply overvoltage is stop even with auto selected
    rst();
    wr(8'h14, 32'h0000_0900);
    wt(300);
    vcc_meas <= 12'ha00;
    wt(200);
    chk(error_code, `DPS_ERR_VOV, "ov");
    chk(uart_param_mode, 1, "stop");
    vcc_meas <= 12'h800;
    rst();
    wr(8'h18, 32'h2);
    wt(300);
    temp_meas <= 12'hd00;
    wt(200);
    chk(latch_mode, 1, "latch");
    rst();
    wt(300);
    chk(gate_drive_output, 2'b00, "hold");
    temp_meas <= 12'h400;
    wt(100);
    chk(gate_drive_output[0], 1, "cool");
    tally_and_finish();
  end
endmodule

bind dps_top dps_checker #(.TICK_CYC(TICK_CYC)) u_chk (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .rvalid, .rready, .rdata,
  .stage1_ready, .stage2_cond, .gate_drive_output, .recharge_only,
  .uart_param_mode, .latch_mode, .error_code, .dim_off);
